// File: design/mmcp_pkg.sv
package mmcp_pkg;

   // Register indices; the byte address on the bus is four times the index.
   localparam int          ADR_W             = 12;
   localparam logic [9:0]  IDX_INPUT_STATUS  = 10'h135;
   localparam logic [9:0]  IDX_LR_LEVEL      = 10'h136;
   localparam logic [9:0]  IDX_LR_DELAY      = 10'h137;
   localparam logic [9:0]  IDX_CMD_IMAGE     = 10'h138;
   localparam logic [9:0]  IDX_IMBAL_THR     = 10'h139;
   localparam logic [9:0]  IDX_PEAK_VOLT_A   = 10'h13a;
   localparam logic [9:0]  IDX_PEAK_VOLT_B   = 10'h13b;
   localparam logic [9:0]  IDX_PEAK_VOLT_C   = 10'h13c;
   localparam logic [9:0]  IDX_PEAK_AMP_A    = 10'h13d;
   localparam logic [9:0]  IDX_PEAK_AMP_B    = 10'h13e;
   localparam logic [9:0]  IDX_PEAK_AMP_C    = 10'h13f;
   localparam logic [9:0]  IDX_SNAP_VOLT_AB  = 10'h140;
   localparam logic [9:0]  IDX_SNAP_VOLT_BC  = 10'h141;
   localparam logic [9:0]  IDX_SNAP_VOLT_CA  = 10'h142;
   localparam logic [9:0]  IDX_FAULT_EN      = 10'h150;
   localparam logic [9:0]  IDX_ALARM_EN      = 10'h151;
   localparam logic [9:0]  IDX_IRQ_STATUS    = 10'h152;
   localparam logic [9:0]  IDX_IRQ_MASK      = 10'h153;

   // Reset values and accepted ranges.
   localparam logic [15:0] LR_LEVEL_RST      = 16'h0258;
   localparam logic [15:0] LR_LEVEL_MIN      = 16'h0190;
   localparam logic [15:0] LR_LEVEL_MAX      = 16'h03e8;
   localparam logic [15:0] LR_DELAY_RST      = 16'h0001;
   localparam logic [15:0] LR_DELAY_MIN      = 16'h0001;
   localparam logic [15:0] LR_DELAY_MAX      = 16'h03e8;
   localparam logic [15:0] IMBAL_THR_RST     = 16'h0000;
   localparam logic [15:0] IMBAL_THR_MAX     = 16'h0064;
   localparam logic [15:0] CMD_IMAGE_RST     = 16'h0000;
   localparam logic [15:0] PEAK_MAX          = 16'h3a98;
   localparam logic [15:0] SNAP_MAX          = 16'h02bc;
   localparam logic [15:0] ENABLE_RST        = 16'h0000;
   localparam logic [15:0] PERCENT_SCALE     = 16'h0064;

   // Delay setting resolution is one tenth of a second.
   localparam int          DELAY_STEP_NS     = 100_000_000;
   localparam int          CLK_PERIOD_NS     = 100;
   localparam int          STEP_CYCLES       = DELAY_STEP_NS / CLK_PERIOD_NS;

   // Command word field positions.
   localparam int          CMD_STOP          = 0;
   localparam int          CMD_START         = 1;
   localparam int          CMD_JOG           = 2;
   localparam int          CMD_CLEAR_FAULT   = 3;
   localparam int          CMD_SLOW_SPEED    = 4;
   localparam int          CMD_EMER_RUN      = 5;
   localparam int          CMD_HEATER        = 6;
   localparam int          CMD_AUX_ENABLE    = 11;
   localparam int          CMD_NET_LSB       = 12;
   localparam logic [15:0] CMD_RESERVED_MASK = 16'h0780;

   // Input status word layout.
   localparam int          IN_W              = 14;
   localparam int          IN_PORT8_IN4      = 9;
   localparam int          IN_PORT9_LSB      = 10;

   // Interrupt status, and the enable bit used by the locked-rotor check.
   localparam int          IRQ_W             = 4;
   localparam int          IRQ_LR_FAULT      = 0;
   localparam int          IRQ_LR_ALARM      = 1;
   localparam int          IRQ_SNAPSHOT      = 2;
   localparam int          IRQ_COMMAND       = 3;
   localparam int          EN_LOCKED_ROTOR   = 0;

   typedef struct packed {
      logic [15:0] a;
      logic [15:0] b;
      logic [15:0] c;
   } mmcp_phase3_t;

   typedef struct packed {
      logic stop;
      logic start;
      logic jog;
      logic clear_fault;
      logic slow_speed;
      logic emer_run;
      logic heater;
   } mmcp_cmd_t;

endpackage : mmcp_pkg

// File: design/mmcp_top.sv
// Local design decision: the Wishbone interface to the registers.
`timescale 1ns/1ns
`default_nettype none

// Function
// [R1] Status bit 9 shows port 8 input 4; bits 10-13 show port 9 inputs 1-4.
// [R2] Status bits 14 and 15 are reserved and always read zero.
// [R3] Stall level takes 400-1000 percent FLC, default 600; exceeding it trips.
// [R4] Stall delay takes 0.1-100.0 s, default 0.1 s, before tripping.
// [R5] Stall trip acts only when its fault-enable or alarm-enable bit is set.
// [R6] Command image is a read-only 16-bit copy of the command word, reset zero.
// [R7] Stop, start and jog fields act on 1 and do nothing on 0.
// [R8] Clear-fault and slow-speed fields act on 1 and do nothing on 0.
// [R9] Emergency-run and heater fields enable on 1 and disable on 0.
// [R10] Network output fields are used only while the aux enable field is 1.
// [R11] Network field n closes its outputs on 1 and opens them on 0.
// [R12] Reserved command fields read as zero.
// [R13] Rebalance threshold takes 0-100 percent; rebalance when imbalance exceeds it.
// [R14] Per-phase peak voltage up to 15000 V is held, cleared at motor start.
// [R15] Per-phase peak current up to 15000 A is held, cleared at motor start.
// [R16] Line voltages up to 700 V are captured on each fault, overwriting.
// [R17] A peak only updates when the new sample is larger.
module mmcp_top
   import mmcp_pkg::*;
#(
   parameter int STEP_CYC = STEP_CYCLES
) (
   input  wire logic                i_clk,
   input  wire logic                i_arst_n,
   input  wire logic                i_wb_cyc,
   input  wire logic                i_wb_stb,
   input  wire logic                i_wb_we,
   input  wire logic [ADR_W-1:0]    i_wb_adr,
   input  wire logic [31:0]         i_wb_dat,
   input  wire logic [3:0]          i_wb_sel,
   output logic      [31:0]         o_wb_dat,
   output logic                     o_wb_ack,
   input  wire logic [IN_W-1:0]     i_din,
   input  wire logic                i_cmd_valid,
   input  wire logic [15:0]         i_cmd_word,
   input  wire logic [15:0]         i_flc_amps,
   input  wire logic                i_sample_valid,
   input  wire mmcp_phase3_t        i_volt,
   input  wire mmcp_phase3_t        i_amp,
   input  wire mmcp_phase3_t        i_line_volt,
   input  wire logic [15:0]         i_imbalance_pct,
   input  wire logic                i_motor_start,
   input  wire logic                i_ext_fault,
   output mmcp_cmd_t                o_cmd,
   output logic      [3:0]          o_net_out,
   output logic                     o_rebalance,
   output logic                     o_lr_fault,
   output logic                     o_lr_alarm,
   output logic                     o_irq
);

   logic [IN_W-1:0]  din_s1_q;
   logic [IN_W-1:0]  din_s2_q;
   logic [15:0]      lr_level_q;
   logic [15:0]      lr_delay_q;
   logic [15:0]      cmd_image_q;
   logic [15:0]      imbal_thr_q;
   logic [15:0]      fault_en_q;
   logic [15:0]      alarm_en_q;
   logic [IRQ_W-1:0] irq_sts_q;
   logic [IRQ_W-1:0] irq_mask_q;
   mmcp_phase3_t     peak_volt_q;
   mmcp_phase3_t     peak_amp_q;
   mmcp_phase3_t     snap_volt_q;
   logic [15:0]      amp_max_q;
   logic [19:0]      step_cnt_q;
   logic [15:0]      tenths_q;
   logic             tripped_q;
   logic             ack_q;
   logic [31:0]      rdat_q;

   logic             req;
   logic             wr;
   logic [9:0]       idx;
   logic [15:0]      status_word;
   logic [15:0]      rd_word;
   logic [15:0]      wr_word;
   logic             over_level;
   logic             step_tick;
   logic             lr_trip;
   logic             fault_evt;
   logic             clear_cmd;
   logic [15:0]      amp_now;
   logic [IRQ_W-1:0] irq_set;

   function automatic logic [15:0] sat(input logic [15:0] v, input logic [15:0] hi);
      sat = (v > hi) ? hi : v;
   endfunction : sat

   function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] lo,
                                         input logic [15:0] hi);
      clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
   endfunction : clamp

   function automatic logic [15:0] peak_next(input logic [15:0] cur, input logic [15:0] s,
                                             input logic clr, input logic vld);
      logic [15:0] base;
      base = clr ? 16'h0000 : cur;
      peak_next = (vld && (sat(s, PEAK_MAX) > base)) ? sat(s, PEAK_MAX) : base; // R17
   endfunction : peak_next

   // Pins from the option modules are asynchronous to the clock.
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         din_s1_q <= '0;
         din_s2_q <= '0;
      end else begin
         din_s1_q <= i_din;
         din_s2_q <= din_s1_q;
      end
   end

   assign status_word = {2'b00, din_s2_q}; // R1 R2

   // Wishbone classic slave: one wait state, ack for one cycle per request.
   assign req = i_wb_cyc && i_wb_stb && !ack_q;
   assign wr  = req && i_wb_we;
   assign idx = i_wb_adr[ADR_W-1:2];

   always_comb begin
      case (idx)
         IDX_INPUT_STATUS: rd_word = status_word;
         IDX_LR_LEVEL:     rd_word = lr_level_q;
         IDX_LR_DELAY:     rd_word = lr_delay_q;
         IDX_CMD_IMAGE:    rd_word = cmd_image_q;
         IDX_IMBAL_THR:    rd_word = imbal_thr_q;
         IDX_PEAK_VOLT_A:  rd_word = peak_volt_q.a;
         IDX_PEAK_VOLT_B:  rd_word = peak_volt_q.b;
         IDX_PEAK_VOLT_C:  rd_word = peak_volt_q.c;
         IDX_PEAK_AMP_A:   rd_word = peak_amp_q.a;
         IDX_PEAK_AMP_B:   rd_word = peak_amp_q.b;
         IDX_PEAK_AMP_C:   rd_word = peak_amp_q.c;
         IDX_SNAP_VOLT_AB: rd_word = snap_volt_q.a;
         IDX_SNAP_VOLT_BC: rd_word = snap_volt_q.b;
         IDX_SNAP_VOLT_CA: rd_word = snap_volt_q.c;
         IDX_FAULT_EN:     rd_word = fault_en_q;
         IDX_ALARM_EN:     rd_word = alarm_en_q;
         IDX_IRQ_STATUS:   rd_word = {12'h000, irq_sts_q};
         IDX_IRQ_MASK:     rd_word = {12'h000, irq_mask_q};
         default:          rd_word = 16'h0000;
      endcase
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         ack_q  <= 1'b0;
         rdat_q <= 32'h0000_0000;
      end else begin
         ack_q  <= req;
         if (req && !i_wb_we) begin
            rdat_q <= {16'h0000, rd_word};
         end
      end
   end

   assign o_wb_ack = ack_q;
   assign o_wb_dat = rdat_q;

   // Byte lanes merge into the current value before range limiting.
   always_comb begin
      wr_word[7:0]  = i_wb_sel[0] ? i_wb_dat[7:0]  : rd_word[7:0];
      wr_word[15:8] = i_wb_sel[1] ? i_wb_dat[15:8] : rd_word[15:8];
   end

   // Out-of-range writes are limited to the nearest legal setting.
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         lr_level_q  <= LR_LEVEL_RST;
         lr_delay_q  <= LR_DELAY_RST;
         imbal_thr_q <= IMBAL_THR_RST;
         fault_en_q  <= ENABLE_RST;
         alarm_en_q  <= ENABLE_RST;
         irq_mask_q  <= '0;
      end else if (wr) begin
         case (idx)
            IDX_LR_LEVEL: lr_level_q <= clamp(wr_word, LR_LEVEL_MIN, LR_LEVEL_MAX); // R3
            IDX_LR_DELAY: lr_delay_q <= clamp(wr_word, LR_DELAY_MIN, LR_DELAY_MAX); // R4
            IDX_IMBAL_THR: imbal_thr_q <= sat(wr_word, IMBAL_THR_MAX); // R13
            IDX_FAULT_EN: fault_en_q <= wr_word;
            IDX_ALARM_EN: alarm_en_q <= wr_word;
            IDX_IRQ_MASK: irq_mask_q <= wr_word[IRQ_W-1:0];
            default: ;
         endcase
      end
   end

   // Command word image and the actions decoded from it.
   assign clear_cmd = i_cmd_valid && i_cmd_word[CMD_CLEAR_FAULT];

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         cmd_image_q <= CMD_IMAGE_RST;
         o_cmd       <= '0;
         o_net_out   <= 4'h0;
      end else if (i_cmd_valid) begin
         cmd_image_q       <= i_cmd_word & ~CMD_RESERVED_MASK; // R6 R12
         o_cmd.stop        <= i_cmd_word[CMD_STOP]; // R7
         o_cmd.start       <= i_cmd_word[CMD_START]; // R7
         o_cmd.jog         <= i_cmd_word[CMD_JOG]; // R7
         o_cmd.clear_fault <= i_cmd_word[CMD_CLEAR_FAULT]; // R8
         o_cmd.slow_speed  <= i_cmd_word[CMD_SLOW_SPEED]; // R8
         o_cmd.emer_run    <= i_cmd_word[CMD_EMER_RUN]; // R9
         o_cmd.heater      <= i_cmd_word[CMD_HEATER]; // R9
         if (i_cmd_word[CMD_AUX_ENABLE]) begin // R10
            o_net_out <= i_cmd_word[CMD_NET_LSB +: 4]; // R11
         end
      end
   end

   // Peak tracking runs over the whole start, run and stop cycle.
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         peak_volt_q <= '0;
         peak_amp_q  <= '0;
      end else begin
         peak_volt_q.a <= peak_next(peak_volt_q.a, i_volt.a, i_motor_start, i_sample_valid); // R14
         peak_volt_q.b <= peak_next(peak_volt_q.b, i_volt.b, i_motor_start, i_sample_valid); // R14
         peak_volt_q.c <= peak_next(peak_volt_q.c, i_volt.c, i_motor_start, i_sample_valid); // R14
         peak_amp_q.a  <= peak_next(peak_amp_q.a, i_amp.a, i_motor_start, i_sample_valid); // R15
         peak_amp_q.b  <= peak_next(peak_amp_q.b, i_amp.b, i_motor_start, i_sample_valid); // R15
         peak_amp_q.c  <= peak_next(peak_amp_q.c, i_amp.c, i_motor_start, i_sample_valid); // R15
      end
   end

   // Highest phase current of the latest sample feeds the stall check.
   always_comb begin
      amp_now = i_amp.a;
      if (i_amp.b > amp_now) begin
         amp_now = i_amp.b;
      end
      if (i_amp.c > amp_now) begin
         amp_now = i_amp.c;
      end
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         amp_max_q <= 16'h0000;
      end else if (i_sample_valid) begin
         amp_max_q <= sat(amp_now, PEAK_MAX);
      end
   end

   // Compare in amps times 100 so that no division is needed.
   assign over_level = (32'(amp_max_q) * 32'(PERCENT_SCALE))
                       > (32'(i_flc_amps) * 32'(lr_level_q)); // R3
   assign step_tick  = over_level && (step_cnt_q == 20'(STEP_CYC - 1));
   assign lr_trip    = over_level && !tripped_q && (tenths_q >= lr_delay_q); // R4

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         step_cnt_q <= 20'h00000;
         tenths_q   <= 16'h0000;
         tripped_q  <= 1'b0;
      end else if (!over_level) begin
         step_cnt_q <= 20'h00000;
         tenths_q   <= 16'h0000;
         tripped_q  <= 1'b0;
      end else begin
         step_cnt_q <= step_tick ? 20'h00000 : step_cnt_q + 20'h00001;
         if (step_tick && (tenths_q < LR_DELAY_MAX)) begin
            tenths_q <= tenths_q + 16'h0001;
         end
         if (lr_trip) begin
            tripped_q <= 1'b1;
         end
      end
   end

   // A latched fault is released by a clear-fault command, but a new trip wins.
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_lr_fault <= 1'b0;
         o_lr_alarm <= 1'b0;
      end else begin
         if (lr_trip && fault_en_q[EN_LOCKED_ROTOR]) begin // R5
            o_lr_fault <= 1'b1;
         end else if (clear_cmd) begin // R8
            o_lr_fault <= 1'b0;
         end
         o_lr_alarm <= (tripped_q || lr_trip) && over_level
                       && alarm_en_q[EN_LOCKED_ROTOR]; // R5
      end
   end

   assign fault_evt = (lr_trip && fault_en_q[EN_LOCKED_ROTOR]) || i_ext_fault;

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         snap_volt_q <= '0;
      end else if (fault_evt) begin
         snap_volt_q.a <= sat(i_line_volt.a, SNAP_MAX); // R16
         snap_volt_q.b <= sat(i_line_volt.b, SNAP_MAX); // R16
         snap_volt_q.c <= sat(i_line_volt.c, SNAP_MAX); // R16
      end
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_rebalance <= 1'b0;
      end else begin
         o_rebalance <= i_imbalance_pct > imbal_thr_q; // R13
      end
   end

   // Interrupt status clears on read; an event in the same cycle is kept.
   always_comb begin
      irq_set               = '0;
      irq_set[IRQ_LR_FAULT] = lr_trip && fault_en_q[EN_LOCKED_ROTOR];
      irq_set[IRQ_LR_ALARM] = lr_trip && alarm_en_q[EN_LOCKED_ROTOR];
      irq_set[IRQ_SNAPSHOT] = fault_evt;
      irq_set[IRQ_COMMAND]  = i_cmd_valid;
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         irq_sts_q <= '0;
         o_irq     <= 1'b0;
      end else begin
         if (req && !i_wb_we && (idx == IDX_IRQ_STATUS)) begin
            irq_sts_q <= irq_set;
         end else begin
            irq_sts_q <= irq_sts_q | irq_set;
         end
         o_irq <= |(irq_sts_q & irq_mask_q);
      end
   end

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_arst_n);

   sequence s_status_read;
      req && !i_wb_we && (idx == IDX_INPUT_STATUS);
   endsequence

   sequence s_cmd_in;
      i_cmd_valid;
   endsequence

   a_status_inputs_map: assert property (s_status_read |=> // R1
      (o_wb_ack && o_wb_dat[13:9] == $past(din_s2_q[13:9])))
      else $error("Input status bits 9 to 13 do not match the inputs.");

   a_status_resv_zero: assert property (s_status_read |=> o_wb_dat[31:14] == '0) // R2
      else $error("Reserved status bits are not zero.");

   a_level_in_range: assert property (lr_level_q >= LR_LEVEL_MIN // R3
      && lr_level_q <= LR_LEVEL_MAX)
      else $error("Stall level left its legal range.");

   a_delay_wait_held: assert property ($rose(tripped_q) |-> // R4
      $past(tenths_q) >= lr_delay_q && lr_delay_q >= LR_DELAY_MIN)
      else $error("Stall trip came before the delay elapsed.");

   a_fault_needs_en: assert property ($rose(o_lr_fault) |-> // R5
      $past(fault_en_q[EN_LOCKED_ROTOR]) && $past(lr_trip))
      else $error("Stall fault set without its enable.");

   a_image_copy_word: assert property (s_cmd_in |=> // R6
      cmd_image_q == ($past(i_cmd_word) & ~CMD_RESERVED_MASK))
      else $error("Command image differs from the command word.");

   a_image_resv_zero: assert property ((cmd_image_q & CMD_RESERVED_MASK) == 16'h0000) // R12
      else $error("Reserved command fields are not zero.");

   a_cmd_decode_map: assert property (s_cmd_in |=> // R7
      o_cmd.stop == $past(i_cmd_word[CMD_STOP]) && o_cmd.start == $past(i_cmd_word[CMD_START])
      && o_cmd.jog == $past(i_cmd_word[CMD_JOG]))
      else $error("Stop, start or jog output is wrong.");

   a_cmd_mode_map: assert property (s_cmd_in |=> // R9
      o_cmd.emer_run == $past(i_cmd_word[CMD_EMER_RUN])
      && o_cmd.heater == $past(i_cmd_word[CMD_HEATER])
      && o_cmd.slow_speed == $past(i_cmd_word[CMD_SLOW_SPEED]))
      else $error("Mode outputs do not follow the command word.");

   a_clear_fault_act: assert property (clear_cmd && !lr_trip |=> !o_lr_fault) // R8
      else $error("Clear-fault command did not clear the fault.");

   a_net_ignored_off: assert property (!(i_cmd_valid && i_cmd_word[CMD_AUX_ENABLE]) // R10
      |=> $stable(o_net_out))
      else $error("Network outputs changed without aux enable.");

   a_net_follow_on: assert property (s_cmd_in ##0 i_cmd_word[CMD_AUX_ENABLE] |=> // R11
      o_net_out == $past(i_cmd_word[CMD_NET_LSB +: 4]))
      else $error("Network outputs do not follow their fields.");

   a_rebal_threshold: assert property (o_rebalance == // R13
      ($past(i_imbalance_pct) > $past(imbal_thr_q)) && imbal_thr_q <= IMBAL_THR_MAX)
      else $error("Rebalance output does not match the threshold.");

   a_volt_clear_start: assert property (i_motor_start && !i_sample_valid |=> // R14
      peak_volt_q == '0 ##1 peak_volt_q.a <= PEAK_MAX)
      else $error("Peak voltage not cleared at motor start.");

   a_amp_clear_start: assert property (i_motor_start && !i_sample_valid |=> // R15
      peak_amp_q == '0)
      else $error("Peak current not cleared at motor start.");

   a_snap_on_fault: assert property (fault_evt |=> // R16
      snap_volt_q.a == sat($past(i_line_volt.a), SNAP_MAX)
      && snap_volt_q.c == sat($past(i_line_volt.c), SNAP_MAX))
      else $error("Line voltages not captured on a fault.");

   a_peak_monotonic: assert property (!i_motor_start |=> // R17
      peak_amp_q.a >= $past(peak_amp_q.a) && peak_volt_q.b >= $past(peak_volt_q.b))
      else $error("A peak value fell without a motor start.");

endmodule : mmcp_top

`default_nettype wire

// File: testbench/mmcp_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module mmcp_host_model (
   input  wire logic        i_clk,
   output logic             o_valid,
   output logic [15:0]      o_word
);
   initial begin
      o_valid = 1'b0;
      o_word  = 16'h0000;
   end
   // Between pulses the word is inverted so that a stale copy can never pass for a fresh one.
   task automatic send(input logic [15:0] w);
      @(posedge i_clk);
      o_valid <= 1'b1;
      o_word  <= w;
      @(posedge i_clk);
      o_valid <= 1'b0;
      o_word  <= ~w;
   endtask : send
endmodule : mmcp_host_model
`default_nettype wire

// File: testbench/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
   import mmcp_pkg::*;
   logic             i_clk, i_arst_n, cyc, stb, we, ack, cmd_v, smp, mst, efl;
   logic             oreb, olrf, olra, oirq;
   logic [ADR_W-1:0] adr;
   logic [31:0]      wdat, rdat;
   logic [3:0]       sel;
   logic [IN_W-1:0]  din;
   logic [15:0]      cmd_w, flc, imb;
   logic [47:0]      volt, amp, lvolt;
   mmcp_cmd_t        ocmd;
   logic [3:0]       onet;
   int               bad_count, comparisons, tmo;
   mmcp_host_model host (.i_clk(i_clk), .o_valid(cmd_v), .o_word(cmd_w));
   mmcp_top #(.STEP_CYC(4)) uut (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_wb_cyc(cyc),
      .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(sel),
      .o_wb_dat(rdat), .o_wb_ack(ack), .i_din(din), .i_cmd_valid(cmd_v), .i_cmd_word(cmd_w),
      .i_flc_amps(flc), .i_sample_valid(smp), .i_volt(volt), .i_amp(amp), .i_line_volt(lvolt),
      .i_imbalance_pct(imb), .i_motor_start(mst), .i_ext_fault(efl), .o_cmd(ocmd),
      .o_net_out(onet), .o_rebalance(oreb), .o_lr_fault(olrf), .o_lr_alarm(olra), .o_irq(oirq));
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      comparisons++;
      if (g !== e) begin
         bad_count++;
         $display("[FAIL] %0t got %h expected %h", $time, g, e);
      end
   endtask : chk
   task automatic step(input int n);
      repeat (n) @(posedge i_clk);
   endtask : step
   // The answer is taken at the edge that shows ack, before that edge's updates land.
   // Only the bench timeout ends a wait for ack.
   task automatic wb(input logic w, input logic [9:0] i, input logic [15:0] d,
                     input logic [3:0] s, output logic [31:0] q);
      @(posedge i_clk);
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      adr  <= {i, 2'b00};
      wdat <= {16'h0000, d};
      sel  <= s;
      do begin
         @(posedge i_clk);
      end while (ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask : wb
   task automatic rd(input logic [9:0] i, input logic [31:0] e);
      logic [31:0] q;
      wb(1'b0, i, 16'h0000, 4'h3, q);
      chk(q, e);
   endtask : rd
   task automatic wr(input logic [9:0] i, input logic [15:0] d);
      logic [31:0] q;
      wb(1'b1, i, d, 4'h3, q);
   endtask : wr
   task automatic pulse(input logic [47:0] v, input logic [47:0] a);
      @(posedge i_clk);
      smp  <= 1'b1;
      volt <= v;
      amp  <= a;
      @(posedge i_clk);
      smp  <= 1'b0;
   endtask : pulse
   task automatic print_verdict();
      $display("mismatches %0d comparisons %0d", bad_count, comparisons);
      if (bad_count == 0 && comparisons > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : print_verdict
   task automatic t_regs();
      logic [31:0] q;
      rd(IDX_LR_LEVEL, 32'h258);
      rd(IDX_LR_DELAY, 32'h1);
      rd(IDX_CMD_IMAGE, 32'h0);
      rd(IDX_PEAK_AMP_A, 32'h0);
      wr(IDX_LR_LEVEL, 16'h0100);
      rd(IDX_LR_LEVEL, 32'h190);
      wr(IDX_LR_LEVEL, 16'h07d0);
      rd(IDX_LR_LEVEL, 32'h3e8);
      wr(IDX_LR_DELAY, 16'h0000);
      rd(IDX_LR_DELAY, 32'h1);
      wr(IDX_IMBAL_THR, 16'h00c8);
      rd(IDX_IMBAL_THR, 32'h64);
      wr(IDX_CMD_IMAGE, 16'h1234);
      rd(IDX_CMD_IMAGE, 32'h0);
      rd(10'h3ff, 32'h0);
      wb(1'b1, IDX_LR_LEVEL, 16'h0090, 4'h1, q);
      rd(IDX_LR_LEVEL, 32'h390);
      wr(IDX_LR_LEVEL, 16'h0258);
      din <= 14'h3e00;
      step(4);
      rd(IDX_INPUT_STATUS, 32'h3e00);
   endtask : t_regs
   task automatic t_cmd();
      host.send(16'hffc5);
      @(negedge i_clk);
      chk({25'h0, ocmd}, 32'h51);
      chk({28'h0, onet}, 32'hf);
      rd(IDX_CMD_IMAGE, 32'hf845);
      host.send(16'h5000);
      @(negedge i_clk);
      chk({25'h0, ocmd}, 32'h0);
      chk({28'h0, onet}, 32'hf);
      host.send(16'h003a);
      @(negedge i_clk);
      chk({25'h0, ocmd}, 32'h2e);
      host.send(16'h5800);
      @(negedge i_clk);
      chk({28'h0, onet}, 32'h5);
   endtask : t_cmd
   task automatic t_peak_rebal();
      pulse(48'h0064_4e20_0005, 48'h000a_000a_000a);
      pulse(48'h0032_0032_0001, 48'h0005_0005_0005);
      step(2);
      rd(IDX_PEAK_VOLT_A, 32'h64);
      rd(IDX_PEAK_VOLT_B, 32'h3a98);
      rd(IDX_PEAK_AMP_B, 32'ha);
      mst <= 1'b1;
      step(1);
      mst <= 1'b0;
      step(2);
      rd(IDX_PEAK_VOLT_A, 32'h0);
      rd(IDX_PEAK_AMP_C, 32'h0);
      wr(IDX_IMBAL_THR, 16'h000a);
      imb <= 16'h000a;
      step(3);
      chk({31'h0, oreb}, 32'h0);
      imb <= 16'h000b;
      step(3);
      chk({31'h0, oreb}, 32'h1);
   endtask : t_peak_rebal
   task automatic t_stall();
      logic [31:0] q;
      int          n;
      wb(1'b0, IDX_IRQ_STATUS, 16'h0000, 4'h3, q);
      wr(IDX_FAULT_EN, 16'h0001);
      wr(IDX_IRQ_MASK, 16'h0001);
      flc <= 16'h0064;
      pulse(48'h0, 48'h02bc_0001_0001);
      n = 0;
      while (olrf !== 1'b1 && n < 60) begin
         @(negedge i_clk);
         n++;
      end
      chk({31'h0, n >= 4 && n <= 12}, 32'h1);
      chk({31'h0, olra}, 32'h0);
      step(2);
      chk({31'h0, oirq}, 32'h1);
      wb(1'b0, IDX_IRQ_STATUS, 16'h0000, 4'h3, q);
      chk({31'h0, q[0]}, 32'h1);
      rd(IDX_IRQ_STATUS, 32'h0);
      step(2);
      chk({31'h0, oirq}, 32'h0);
      host.send(16'h0008);
      @(negedge i_clk);
      chk({31'h0, olrf}, 32'h0);
      wr(IDX_ALARM_EN, 16'h0001);
      step(2);
      chk({31'h0, olra}, 32'h1);
   endtask : t_stall
   task automatic t_snap();
      step(1);
      lvolt <= 48'h0320_012c_02bc;
      efl   <= 1'b1;
      step(1);
      efl   <= 1'b0;
      step(2);
      rd(IDX_SNAP_VOLT_AB, 32'h2bc);
      rd(IDX_SNAP_VOLT_BC, 32'h12c);
      lvolt <= 48'h0001_0002_0003;
      efl   <= 1'b1;
      step(1);
      efl   <= 1'b0;
      step(2);
      rd(IDX_SNAP_VOLT_CA, 32'h3);
   endtask : t_snap
   initial begin
      i_clk = 1'b0;
      forever #50 i_clk = ~i_clk;
   end
   always @(posedge i_clk) begin
      tmo++;
      if (tmo == 20000) begin
         bad_count++;
         print_verdict();
      end
   end
   initial begin
      {cyc, stb, we, smp, mst, efl, i_arst_n} = '0;
      {adr, wdat, sel, din, flc, imb, volt, amp, lvolt} = '0;
      step(3);
      i_arst_n <= 1'b1;
      t_regs();
      t_cmd();
      t_peak_rebal();
      t_stall();
      t_snap();
      print_verdict();
   end
endmodule : tb
`default_nettype wire
